// File: src/cipg_top.sv
// Top of the counter indexed pattern output: register port, index forming and output stage.
// Assumes the count input is the unsigned 16-bit count of counter timer 0, on sys_clk.
`timescale 1ns/1ps

// Summary of operation
// - Index is the count's low 13 bits.
// - Select disables or picks pattern 1 to 10.
// - Disabled select holds the output at 0.
// - Output is the selected pattern's bit at index.
// - Index beyond defined points drives output Low.
// - Index always comes from counter timer 0.
// - Each pattern holds up to 8192 one-bit points.
// - Block exists only for 16-bit unsigned counters.
module cipg_top
   import cipg_pkg::*;
#(
   parameter int CNT_W   = cipg_pkg::CIPG_CNT_W,
   parameter int NUM_PAT = cipg_pkg::CIPG_NUM_PAT,
   parameter int DEPTH   = cipg_pkg::CIPG_DEPTH
) (
   input  wire logic                             sys_clk,
   input  wire logic                             rst_b,
   input  wire logic [CNT_W-1:0]                 ct0_count,
   input  wire logic [cipg_pkg::CIPG_ADDR_W-1:0] reg_addr,
   input  wire logic [cipg_pkg::CIPG_DATA_W-1:0] reg_wdata,
   input  wire logic                             reg_wr,
   input  wire logic                             reg_rd,
   output logic      [cipg_pkg::CIPG_DATA_W-1:0] reg_rdata,
   output logic                                  pg_out
);
   import cipg_pkg::*;

   // ==========================================================================
   // Declarations
   // ==========================================================================
   logic [CIPG_SEL_W-1:0]  sel_q,    sel_d;     // Active pattern, 0 is disabled.
   logic [CIPG_SEL_W-1:0]  ldpat_q,  ldpat_d;   // Pattern the loader writes.
   logic [CIPG_IDX_W-1:0]  ldaddr_q, ldaddr_d;  // Point the loader writes next.
   logic [CIPG_DATA_W-1:0] rdata_q,  rdata_d;   // Read answer, one cycle after the strobe.
   logic                   out_q,    out_d;     // Pattern output flip-flop.
   logic [CIPG_IDX_W-1:0]  idx;                 // Point index from the count.
   logic                   wr_bit_en;           // Loader writes one point bit.
   logic                   wr_cnt_en;           // Loader writes the point count.
   logic [CIPG_PTS_W-1:0]  wr_cnt;              // Point count after clamping.
   logic                   pat_bit;             // Stored bit at the live index.
   logic [CIPG_PTS_W-1:0]  pat_cnt;             // Points of the selected pattern.
   logic                   sw_bit;              // Stored bit at the loader address.
   logic [CIPG_PTS_W-1:0]  sw_cnt;              // Points of the loader's pattern.

   // The block is only built for an unsigned 16-bit counter group.
   if (CNT_W != 16) begin : g_bad_width
      $error("Pattern output needs a 16-bit unsigned count.");
   end

   // ==========================================================================
   // Index forming
   // ==========================================================================
   // Dropping the upper bits is the same as the remainder after division by 8192.
   // The count port is the only index source; nothing in the map can reroute it.
   assign idx = ct0_count[CIPG_IDX_W-1:0];

   // ==========================================================================
   // Pattern storage
   // ==========================================================================
   cipg_pattern_mem #(
      .NUM_PAT (NUM_PAT),
      .DEPTH   (DEPTH),
      .IDX_W   (CIPG_IDX_W),
      .PTS_W   (CIPG_PTS_W)
   ) u_mem (
      .sys_clk   (sys_clk),
      .rst_b     (rst_b),
      .wr_bit_en (wr_bit_en),
      .wr_cnt_en (wr_cnt_en),
      .wr_pat    (ldpat_q),
      .wr_addr   (ldaddr_q),
      .wr_bit    (reg_wdata[0]),
      .wr_cnt    (wr_cnt),
      .rd_pat    (sel_q),
      .rd_addr   (idx),
      .rd_bit    (pat_bit),
      .rd_cnt    (pat_cnt),
      .sw_pat    (ldpat_q),
      .sw_addr   (ldaddr_q),
      .sw_bit    (sw_bit),
      .sw_cnt    (sw_cnt)
   );

   // ==========================================================================
   // Register writes
   // ==========================================================================
   // Select and loader pattern writes out of range are ignored rather than clipped, so a bad select can never
   // point the output at an empty slot by accident.
   always_comb begin
      sel_d     = sel_q;
      ldpat_d   = ldpat_q;
      ldaddr_d  = ldaddr_q;
      wr_bit_en = 1'b0;
      wr_cnt_en = 1'b0;
      wr_cnt    = reg_wdata[CIPG_PTS_W-1:0];
      // Bits above the count field still mean a count beyond the depth, so they clamp too.
      if ((reg_wdata[CIPG_DATA_W-1:CIPG_PTS_W] != '0) || (reg_wdata[CIPG_PTS_W-1:0] > CIPG_PTS_MAX)) begin
         wr_cnt = CIPG_PTS_MAX;
      end
      if (reg_wr) begin
         if (reg_addr == CIPG_OFS_SEL) begin
            // Zero disables; 1 to 10 choose a pattern.
            if ((reg_wdata[CIPG_DATA_W-1:CIPG_SEL_W] == '0) &&
                (reg_wdata[CIPG_SEL_W-1:0] <= CIPG_SEL_MAX)) begin
               sel_d = reg_wdata[CIPG_SEL_W-1:0];
            end
         end else if (reg_addr == CIPG_OFS_LDPAT) begin
            if ((reg_wdata[CIPG_DATA_W-1:CIPG_SEL_W] == '0) &&
                cipg_sel_valid(reg_wdata[CIPG_SEL_W-1:0])) begin
               ldpat_d = reg_wdata[CIPG_SEL_W-1:0];
            end
         end else if (reg_addr == CIPG_OFS_LDADDR) begin
            ldaddr_d = reg_wdata[CIPG_IDX_W-1:0];
         end else if (reg_addr == CIPG_OFS_LDDATA) begin
            // Stepping the address lets software stream a whole table in order.
            wr_bit_en = 1'b1;
            ldaddr_d  = ldaddr_q + 13'h0001;
         end else if (reg_addr == CIPG_OFS_POINTS) begin
            wr_cnt_en = 1'b1;
         end
      end
   end

   // Register write state.
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         sel_q    <= CIPG_SEL_DISABLED;
         ldpat_q  <= CIPG_LDPAT_RST;
         ldaddr_q <= '0;
      end else begin
         sel_q    <= sel_d;
         ldpat_q  <= ldpat_d;
         ldaddr_q <= ldaddr_d;
      end
   end

   // ==========================================================================
   // Register reads
   // ==========================================================================
   // The answer stands only in the cycle after the strobe and is zero otherwise.
   always_comb begin
      rdata_d = '0;
      if (reg_rd) begin
         if (reg_addr == CIPG_OFS_SEL) begin
            rdata_d[CIPG_SEL_W-1:0] = sel_q;
         end else if (reg_addr == CIPG_OFS_LDPAT) begin
            rdata_d[CIPG_SEL_W-1:0] = ldpat_q;
         end else if (reg_addr == CIPG_OFS_LDADDR) begin
            rdata_d[CIPG_IDX_W-1:0] = ldaddr_q;
         end else if (reg_addr == CIPG_OFS_LDDATA) begin
            rdata_d[0] = sw_bit;
         end else if (reg_addr == CIPG_OFS_POINTS) begin
            rdata_d[CIPG_PTS_W-1:0] = sw_cnt;
         end else if (reg_addr == CIPG_OFS_STATUS) begin
            rdata_d[CIPG_ST_IDX_POS +: CIPG_IDX_W] = idx;
            rdata_d[CIPG_ST_OUT_POS]               = out_q;
            rdata_d[CIPG_ST_SEL_POS +: CIPG_SEL_W] = sel_q;
         end
      end
   end

   // ==========================================================================
   // Output stage
   // ==========================================================================
   // The output is re-evaluated every cycle, so it follows any count change one clock later.
   always_comb begin
      out_d = 1'b0;
      if (cipg_sel_valid(sel_q)) begin
         if ({1'b0, idx} < pat_cnt) begin
            out_d = pat_bit;
         end else begin
            out_d = 1'b0;
         end
      end
   end

   // Output and read data flip-flops.
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         out_q   <= 1'b0;
         rdata_q <= '0;
      end else begin
         out_q   <= out_d;
         rdata_q <= rdata_d;
      end
   end

   assign pg_out    = out_q;
   assign reg_rdata = rdata_q;

   // ==========================================================================
   // Assertions
   // ==========================================================================
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_b);

   // A write to the select register, whatever pattern it carries.
   sequence s_sel_write;
      reg_wr && (reg_addr == CIPG_OFS_SEL);
   endsequence

   sequence s_no_read;
      !reg_rd;
   endsequence

   a_disabled_low: assert property ((sel_q == CIPG_SEL_DISABLED) [*2] |=> !pg_out)
      else $error("Output high while disabled.");

   a_sel_in_range: assert property (s_sel_write |=> (sel_q <= CIPG_SEL_MAX))
      else $error("Pattern select left the legal range.");

   a_status_index: assert property (reg_rd && (reg_addr == CIPG_OFS_STATUS) |=>
      (reg_rdata[CIPG_ST_IDX_POS +: CIPG_IDX_W] == $past(ct0_count[CIPG_IDX_W-1:0])))
      else $error("Status index is not the low count bits.");

   a_out_follows: assert property (cipg_sel_valid(sel_q) && ({1'b0, idx} < pat_cnt) |=>
      (pg_out == $past(pat_bit)))
      else $error("Output does not follow the stored point.");

   a_out_beyond: assert property (cipg_sel_valid(sel_q) && ({1'b0, idx} >= pat_cnt) |=> !pg_out)
      else $error("Output high beyond the defined points.");

   a_load_step: assert property (reg_wr && (reg_addr == CIPG_OFS_LDDATA) |=>
      (ldaddr_q == $past(ldaddr_q) + 13'h0001))
      else $error("Loader address did not step.");

   a_points_cap: assert property (reg_wr && (reg_addr == CIPG_OFS_POINTS) |=> ##1
      (sw_cnt <= CIPG_PTS_MAX) || ($past(ldpat_q, 2) != ldpat_q))
      else $error("Point count above the pattern depth.");

   a_rdata_idle: assert property (s_no_read |=> (reg_rdata == '0))
      else $error("Read data present without a read.");

   // A read of the status word, answered in the next cycle.
   sequence s_status_read;
      reg_rd && (reg_addr == CIPG_OFS_STATUS);
   endsequence

   // A write of a point count to the loader's pattern.
   sequence s_points_write;
      reg_wr && (reg_addr == CIPG_OFS_POINTS);
   endsequence

   // A legal select write is in force one cycle later.
   a_sel_taken: assert property (s_sel_write ##0 (reg_wdata <= 32'(CIPG_SEL_MAX)) |=>
      (sel_q == $past(reg_wdata[CIPG_SEL_W-1:0])))
      else $error("Legal pattern select was not taken.");

   // An out-of-range select write changes nothing.
   a_sel_ignored: assert property (s_sel_write ##0 (reg_wdata > 32'(CIPG_SEL_MAX)) |=> $stable(sel_q))
      else $error("Illegal pattern select was taken.");

   // The loader never moves to pattern 0 or past pattern 10.
   a_ldpat_ignored: assert property (reg_wr && (reg_addr == CIPG_OFS_LDPAT) &&
      ((reg_wdata == '0) || (reg_wdata > 32'(CIPG_SEL_MAX))) |=> $stable(ldpat_q))
      else $error("Illegal loader pattern was taken.");

   // A loader address write lands as written.
   a_ldaddr_write: assert property (reg_wr && (reg_addr == CIPG_OFS_LDADDR) |=>
      (ldaddr_q == $past(reg_wdata[CIPG_IDX_W-1:0])))
      else $error("Loader address write was lost.");

   // A count above the depth is stored as the depth, so a table never overruns.
   a_points_clamp: assert property (s_points_write ##0 (reg_wdata > 32'(CIPG_PTS_MAX)) |=>
      (sw_cnt == CIPG_PTS_MAX))
      else $error("Point count was not clamped to the depth.");

   // A count within the depth is stored unchanged.
   a_points_exact: assert property (s_points_write ##0 (reg_wdata <= 32'(CIPG_PTS_MAX)) |=>
      (sw_cnt == $past(reg_wdata[CIPG_PTS_W-1:0])))
      else $error("Point count was not stored as written.");

   // The status word carries the output level and the select of the read cycle.
   a_status_out: assert property (s_status_read |=> (reg_rdata[CIPG_ST_OUT_POS] == $past(pg_out)))
      else $error("Status output bit is wrong.");

   a_status_sel: assert property (s_status_read |=>
      (reg_rdata[CIPG_ST_SEL_POS +: CIPG_SEL_W] == $past(sel_q)))
      else $error("Status select field is wrong.");

   // Register reads answer with the value held in the strobe cycle, upper bits zero.
   a_rdata_sel: assert property (reg_rd && (reg_addr == CIPG_OFS_SEL) |=>
      (reg_rdata == 32'($past(sel_q))))
      else $error("Select read back is wrong.");

   a_rdata_ldaddr: assert property (reg_rd && (reg_addr == CIPG_OFS_LDADDR) |=>
      (reg_rdata == 32'($past(ldaddr_q))))
      else $error("Loader address read back is wrong.");

   a_rdata_points: assert property (reg_rd && (reg_addr == CIPG_OFS_POINTS) |=>
      (reg_rdata == 32'($past(sw_cnt))))
      else $error("Point count read back is wrong.");

   a_rdata_bit: assert property (reg_rd && (reg_addr == CIPG_OFS_LDDATA) |=>
      (reg_rdata == 32'($past(sw_bit))))
      else $error("Stored point read back is wrong.");

endmodule

// File: shared/cipg_pkg.sv
// Constants, field layouts and helpers shared by the counter indexed pattern output block.
// Assumes a single 100 MHz system clock and a plain register port on the top module.
package cipg_pkg;

   // ==========================================================================
   // Sizes
   // ==========================================================================
   localparam int CIPG_CNT_W   = 16;     // Width of the unsigned count from counter timer 0.
   localparam int CIPG_IDX_W   = 13;     // Point index keeps the low 13 bits of the count.
   localparam int CIPG_DEPTH   = 8192;   // Points held by each pattern.
   localparam int CIPG_NUM_PAT = 10;     // Number of stored patterns.
   localparam int CIPG_SEL_W   = 4;      // Width of a pattern number.
   localparam int CIPG_PTS_W   = 14;     // Point count, 0 up to 8192 inclusive.
   localparam int CIPG_ADDR_W  = 8;      // Register address width.
   localparam int CIPG_DATA_W  = 32;     // Register data width.

   // ==========================================================================
   // Register offsets
   // ==========================================================================
   localparam logic [CIPG_ADDR_W-1:0] CIPG_OFS_SEL    = 8'h00;  // Pattern select.
   localparam logic [CIPG_ADDR_W-1:0] CIPG_OFS_LDPAT  = 8'h04;  // Pattern being loaded.
   localparam logic [CIPG_ADDR_W-1:0] CIPG_OFS_LDADDR = 8'h08;  // Point being loaded.
   localparam logic [CIPG_ADDR_W-1:0] CIPG_OFS_LDDATA = 8'h0C;  // Point bit, auto increment.
   localparam logic [CIPG_ADDR_W-1:0] CIPG_OFS_POINTS = 8'h10;  // Point count of loaded pattern.
   localparam logic [CIPG_ADDR_W-1:0] CIPG_OFS_STATUS = 8'h14;  // Live index, output, select.

   // ==========================================================================
   // Field positions and reset values
   // ==========================================================================
   localparam int CIPG_ST_IDX_POS = 0;   // Status: current point index.
   localparam int CIPG_ST_OUT_POS = 16;  // Status: output level.
   localparam int CIPG_ST_SEL_POS = 20;  // Status: active pattern select.

   localparam logic [CIPG_SEL_W-1:0] CIPG_SEL_DISABLED = 4'h0;   // Default: block disabled.
   localparam logic [CIPG_SEL_W-1:0] CIPG_SEL_MAX      = 4'hA;   // Highest pattern number.
   localparam logic [CIPG_SEL_W-1:0] CIPG_LDPAT_RST    = 4'h1;   // Loader starts on pattern 1.
   localparam logic [CIPG_PTS_W-1:0] CIPG_PTS_MAX      = 14'h2000; // Longest legal pattern.
   localparam logic [CIPG_PTS_W-1:0] CIPG_PTS_RST      = 14'h0000; // Empty pattern drives Low.

   // A pattern number is usable when it lies in 1 to 10.
   function automatic logic cipg_sel_valid(input logic [CIPG_SEL_W-1:0] sel);
      cipg_sel_valid = (sel != CIPG_SEL_DISABLED) && (sel <= CIPG_SEL_MAX);
   endfunction

endpackage

// File: src/cipg_pattern_mem.sv
// Flip-flop storage of all pattern bits and per-pattern point counts.
// Assumes pattern numbers at its ports are 1-based and already checked by the caller.
`timescale 1ns/1ps

module cipg_pattern_mem
   import cipg_pkg::*;
#(
   parameter int NUM_PAT = cipg_pkg::CIPG_NUM_PAT,
   parameter int DEPTH   = cipg_pkg::CIPG_DEPTH,
   parameter int IDX_W   = cipg_pkg::CIPG_IDX_W,
   parameter int PTS_W   = cipg_pkg::CIPG_PTS_W
) (
   input  wire logic                            sys_clk,
   input  wire logic                            rst_b,
   input  wire logic                            wr_bit_en,
   input  wire logic                            wr_cnt_en,
   input  wire logic [cipg_pkg::CIPG_SEL_W-1:0] wr_pat,
   input  wire logic [IDX_W-1:0]                wr_addr,
   input  wire logic                            wr_bit,
   input  wire logic [PTS_W-1:0]                wr_cnt,
   input  wire logic [cipg_pkg::CIPG_SEL_W-1:0] rd_pat,
   input  wire logic [IDX_W-1:0]                rd_addr,
   output logic                                 rd_bit,
   output logic [PTS_W-1:0]                     rd_cnt,
   input  wire logic [cipg_pkg::CIPG_SEL_W-1:0] sw_pat,
   input  wire logic [IDX_W-1:0]                sw_addr,
   output logic                                 sw_bit,
   output logic [PTS_W-1:0]                     sw_cnt
);
   import cipg_pkg::*;

   // ==========================================================================
   // Storage
   // ==========================================================================
   logic [DEPTH-1:0] bits_q   [NUM_PAT];  // One bit per point, 1 means High.
   logic [DEPTH-1:0] bits_d   [NUM_PAT];  // Next value of each pattern.
   logic [PTS_W-1:0] pts_q    [NUM_PAT];  // Defined points of each pattern.
   logic [PTS_W-1:0] pts_d    [NUM_PAT];  // Next point counts.

   // Each pattern slot decodes its own write, so only one slot changes per cycle.
   for (genvar p = 0; p < NUM_PAT; p++) begin : g_pat
      always_comb begin
         bits_d[p] = bits_q[p];
         pts_d[p]  = pts_q[p];
         if (wr_bit_en && (int'(wr_pat) == p + 1)) begin
            bits_d[p][wr_addr] = wr_bit;
         end
         if (wr_cnt_en && (int'(wr_pat) == p + 1)) begin
            pts_d[p] = wr_cnt;
         end
      end

      // Cleared tables mean an unloaded pattern only ever drives Low.
      always_ff @(posedge sys_clk or negedge rst_b) begin
         if (!rst_b) begin
            bits_q[p] <= '0;
            pts_q[p]  <= CIPG_PTS_RST;
         end else begin
            bits_q[p] <= bits_d[p];
            pts_q[p]  <= pts_d[p];
         end
      end
   end

   // ==========================================================================
   // Read ports
   // ==========================================================================
   // Both reads are combinational so the caller can register within one clock.
   always_comb begin
      rd_bit = 1'b0;
      rd_cnt = '0;
      sw_bit = 1'b0;
      sw_cnt = '0;
      for (int p = 0; p < NUM_PAT; p++) begin
         if (int'(rd_pat) == p + 1) begin
            rd_bit = bits_q[p][rd_addr];
            rd_cnt = pts_q[p];
         end
         if (int'(sw_pat) == p + 1) begin
            sw_bit = bits_q[p][sw_addr];
            sw_cnt = pts_q[p];
         end
      end
   end

endmodule

// File: verif/cipg_ct0_model.sv
// ==========================================================================
// Model of counter timer 0, the source of the pattern index.
// ==========================================================================
// Assumes the bench drives load and step by non-blocking assignment after sys_clk rises.
`timescale 1ns/1ps

module cipg_ct0_model
   import cipg_pkg::*;
(
   input  wire logic                            sys_clk,
   input  wire logic                            rst_b,
   input  wire logic                            load,
   input  wire logic [cipg_pkg::CIPG_CNT_W-1:0] load_val,
   input  wire logic                            step,
   input  wire logic [cipg_pkg::CIPG_CNT_W-1:0] upper,
   output logic      [cipg_pkg::CIPG_CNT_W-1:0] count
);
   logic [CIPG_CNT_W-1:0] count_q;  // Present count.
   logic [CIPG_CNT_W-1:0] count_d;  // Next count.

   // A load wins over a ring step, so the bench can jump anywhere at once.
   always_comb begin
      count_d = count_q;
      if (load) begin
         count_d = load_val;
      end else if (step) begin
         count_d = (count_q >= upper) ? 16'h0000 : count_q + 16'h0001;
      end
   end

   // The count is a level that never floats, so no release pattern is needed.
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         count_q <= 16'h0000;
      end else begin
         count_q <= count_d;
      end
   end

   assign count = count_q;
endmodule

// File: verif/test_counter_indexed_pattern_output.sv
// ==========================================================================
// Self-checking bench for the counter indexed pattern output.
// ==========================================================================
// Assumes cipg_top and the counter model; every wait is a fixed, bounded count.
`timescale 1ns/1ps

module test_counter_indexed_pattern_output
   import cipg_pkg::*;
;
   logic                   sys_clk   = 1'b0;
   logic                   rst_b     = 1'b0;
   logic [CIPG_ADDR_W-1:0] reg_addr  = 8'h00;
   logic [CIPG_DATA_W-1:0] reg_wdata = 32'h0000_0000;
   logic                   reg_wr    = 1'b0;
   logic                   reg_rd    = 1'b0;
   logic [CIPG_DATA_W-1:0] reg_rdata;
   logic                   pg_out;
   logic                   ld        = 1'b0;
   logic                   stp       = 1'b0;
   logic [CIPG_CNT_W-1:0]  ld_val    = 16'h0000;
   logic [CIPG_CNT_W-1:0]  upper     = 16'h0006;
   logic [CIPG_CNT_W-1:0]  cnt;
   logic [CIPG_DATA_W-1:0] d;
   logic                   exp_mem [1:10][0:8191] = '{default: 1'b0};  // Bench copy of the tables.
   int                     pts [1:10] = '{default: 0};                 // Bench copy of point counts.
   logic [3:0]             sel_m = 4'h0;                               // Select the design should hold.
   int                     errors = 0;
   int                     check_count = 0;

   always #5 sys_clk = ~sys_clk;

   cipg_ct0_model u_ct0 (.sys_clk(sys_clk), .rst_b(rst_b), .load(ld), .load_val(ld_val),
                         .step(stp), .upper(upper), .count(cnt));
   cipg_top u_dut (.sys_clk(sys_clk), .rst_b(rst_b), .ct0_count(cnt), .reg_addr(reg_addr),
                   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
                   .pg_out(pg_out));

   // Expected output level for a select and a raw count.
   function automatic logic exp_out(input logic [3:0] s, input logic [15:0] c);
      int i;
      i = int'(c) % CIPG_DEPTH;
      if (s == 4'h0 || s > 4'hA) return 1'b0;
      if (i >= pts[s]) return 1'b0;
      return exp_mem[s][i];
   endfunction

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] expv);
      check_count++;
      if (seen !== expv) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", name, expv, seen);
      end
   endtask

   task automatic end_of_test;
      $display("checks %0d errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // Bus tasks start just after a rising edge; a spare cycle keeps strobes apart.
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
      @(posedge sys_clk);
   endtask

   // Read data stands only in the cycle after the strobe, so it is taken mid-cycle.
   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      @(negedge sys_clk);
      v = reg_rdata;
      @(posedge sys_clk);
   endtask

   task automatic sel(input logic [31:0] s);
      wr(CIPG_OFS_SEL, s);
      if (s <= 32'h0000_000A) sel_m = s[3:0];
      repeat (2) @(posedge sys_clk);
      rd(CIPG_OFS_SEL, d);
      check("select", d, {28'h0, sel_m});
   endtask

   task automatic set_pts(input int p, input int n);
      wr(CIPG_OFS_LDPAT, 32'(p));
      wr(CIPG_OFS_POINTS, 32'(n));
      pts[p] = (n > CIPG_DEPTH) ? CIPG_DEPTH : n;
      rd(CIPG_OFS_POINTS, d);
      check("points", d, 32'(pts[p]));
   endtask

   // Output and status are compared once the count has settled for two cycles.
   task automatic chk_out(input logic [15:0] c);
      @(negedge sys_clk);
      check("pg_out", {31'h0, pg_out}, {31'h0, exp_out(sel_m, c)});
      @(posedge sys_clk);
      rd(CIPG_OFS_STATUS, d);
      check("status", 32'({d[23:20], d[16], d[12:0]}), 32'({sel_m, exp_out(sel_m, c), c[12:0]}));
   endtask

   task automatic at(input logic [15:0] c);
      ld <= 1'b1;
      ld_val <= c;
      @(posedge sys_clk);
      ld <= 1'b0;
      repeat (2) @(posedge sys_clk);
      chk_out(c);
   endtask

   // Watchdog: a hang counts as a mismatch and goes to the closing report.
   initial begin
      repeat (100000) @(posedge sys_clk);
      errors++;
      end_of_test();
   end

   initial begin
      logic b;
      logic [15:0] corner [5];
      corner = '{16'h1FFF, 16'h2000, 16'h2710, 16'h4E20, 16'hFFFF};
      void'($urandom(68650));
      repeat (16) @(posedge sys_clk);
      rst_b <= 1'b1;
      @(posedge sys_clk);
      // Reset values and an unmapped address; the output is looked at mid-cycle.
      @(negedge sys_clk);
      check("pg_out_rst", {31'h0, pg_out}, 32'h0000_0000);
      @(posedge sys_clk);
      rd(CIPG_OFS_LDPAT, d);
      check("ldpat_rst", d, 32'h0000_0001);
      rd(8'h18, d);
      check("unmapped", d, 32'h0000_0000);
      sel(32'h0000_0000);
      // Six point example, stepped by the ring counter.
      wr(CIPG_OFS_LDPAT, 32'h0000_0001);
      wr(CIPG_OFS_LDADDR, 32'h0000_0000);
      for (int i = 0; i < 6; i++) begin
         exp_mem[1][i] = 1'(6'h2C >> i);
         wr(CIPG_OFS_LDDATA, {31'h0, exp_mem[1][i]});
      end
      // Reading a stored point leaves the loader address where it is.
      wr(CIPG_OFS_LDADDR, 32'h0000_0002);
      rd(CIPG_OFS_LDDATA, d);
      check("lddata_rd", d, {31'h0, exp_mem[1][2]});
      rd(CIPG_OFS_LDADDR, d);
      check("ldaddr_hold", d, 32'h0000_0002);
      set_pts(1, 6);
      sel(32'h0000_0001);
      at(16'h0000);
      for (int k = 0; k < 9; k++) begin
         stp <= 1'b1;
         @(posedge sys_clk);
         stp <= 1'b0;
         repeat (2) @(posedge sys_clk);
         chk_out(cnt);
      end
      at(16'h0064);
      at(16'h2002);
      sel(32'h0000_000B);
      sel(32'h0000_0011);
      wr(CIPG_OFS_LDPAT, 32'h0000_0000);
      rd(CIPG_OFS_LDPAT, d);
      check("ldpat_zero", d, 32'h0000_0001);
      // Full pattern of random bits, the address wrapping at the end.
      wr(CIPG_OFS_LDPAT, 32'h0000_0002);
      wr(CIPG_OFS_LDADDR, 32'h0000_0000);
      for (int i = 0; i < CIPG_DEPTH; i++) begin
         b = 1'($urandom_range(1, 0));
         exp_mem[2][i] = b;
         wr(CIPG_OFS_LDDATA, {31'h0, b});
      end
      rd(CIPG_OFS_LDADDR, d);
      check("ldaddr_wrap", d, 32'h0000_0000);
      set_pts(2, 65541);
      set_pts(2, 65535);
      sel(32'h0000_0002);
      foreach (corner[i]) at(corner[i]);
      for (int i = 0; i < 30; i++) at(16'($urandom()));
      // Every pattern number, one marked point each.
      for (int p = 1; p <= 10; p++) begin
         wr(CIPG_OFS_LDPAT, 32'(p));
         wr(CIPG_OFS_LDADDR, 32'(7000 + p));
         wr(CIPG_OFS_LDDATA, 32'h0000_0001);
         exp_mem[p][7000 + p] = 1'b1;
         if (p > 2) set_pts(p, 8000);
      end
      for (int p = 1; p <= 10; p++) begin
         sel(32'(p));
         at(16'(7000 + p));
         at(16'(7000 + p + CIPG_DEPTH));
      end
      // Disabled select forces Low whatever the count.
      sel(32'h0000_0000);
      at(16'h1B5B);
      for (int i = 0; i < 5; i++) at(16'($urandom()));
      end_of_test();
   end
endmodule
